// ### logic/opd_core.sv
// ---------------------------------------------------------------
// Overview of operation
// - external clock option turns the shared pin into an ordinary port bit.
// - RC or ceramic options give the shared pin to the oscillator, no port.
// - undivided clock path is legal with every oscillator source except a 4 MHz ceramic.
// - divide by three or four only with external clock or ceramic.
// - a 400 kHz ceramic resonator is used undivided only.
// - standard part: 4 MHz ceramic needs divide by three or four.
// - low-voltage part: 4 MHz ceramic only with divide by four.
// - in reset ports C and D drive one option level per group.
// - each port bit is open drain or driven with pull-up, per option.
// - no pull-up on the shared pin when the oscillator owns it.
// ---------------------------------------------------------------
`include "opd_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module opd_core
    import opd_pkg::*;
#(
    parameter int PORT_BITS = 13
) (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire opd_opt_t    opt_in,
    input  wire logic [12:0] pin_level_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output opd_apb_rsp_t     apb_out,
    output opd_pins_t        pins_out,
    output logic             cycle_tick_out,
    output logic             osc_return_pin_out,
    output logic             cfg_legal_out
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  div_cnt;
        logic [1:0]  phase;
        logic        tick;
        logic        osc_ret;
        logic        legal;
        logic [12:0] port_data;
        logic [12:0] sync1;
        logic [12:0] sync2;
        opd_pins_t   pins;
        opd_apb_rsp_t apb;
    } opd_state_t;

    opd_state_t state_reg;
    opd_state_t state_next;

    // legality of source, ratio and resonator combination
    function automatic logic opd_legal(input opd_opt_t o);
        logic ok;
        ok = 1'b1;
        if (o.src == OPD_SRC_RC && o.div != OPD_DIV_1)
            ok = 1'b0;
        if (o.div != OPD_DIV_1 && o.div != OPD_DIV_3 && o.div != OPD_DIV_4)
            ok = 1'b0;
        if (o.src == OPD_SRC_CER && o.freq == OPD_F_400K && o.div != OPD_DIV_1)
            ok = 1'b0;
        if (o.src == OPD_SRC_CER && o.freq == OPD_F_4M && !o.low_v && o.div == OPD_DIV_1)
            ok = 1'b0;
        if (o.src == OPD_SRC_CER && o.freq == OPD_F_4M && o.low_v && o.div != OPD_DIV_4)
            ok = 1'b0;
        if (o.src != OPD_SRC_EXT && o.src != OPD_SRC_RC && o.src != OPD_SRC_CER)
            ok = 1'b0;
        return ok;
    endfunction : opd_legal

    // predivider terminal count, ratio minus one
    function automatic logic [1:0] opd_div_top(input opd_div_t d);
        logic [1:0] t;
        t = 2'h0;
        unique case (d)
            OPD_DIV_3: t = 2'h2;
            OPD_DIV_4: t = 2'h3;
            default:   t = 2'h0;
        endcase
        return t;
    endfunction : opd_div_top

    // reset-time pin vector: A and H released, C and D at their option level
    function automatic logic [12:0] opd_reset_pins(input opd_opt_t o);
        return {1'b1, {4{o.resd_high}}, {4{o.resc_high}}, 4'hF};
    endfunction : opd_reset_pins

    logic shared_is_port;
    logic [11:0] addr_word;

    // oscillator takes the shared pin unless the clock comes in from outside
    assign shared_is_port = (opt_in.src == OPD_SRC_EXT);
    assign addr_word      = paddr_in;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.sync1 = pin_level_in;
        state_next.sync2 = state_reg.sync1;
        state_next.legal = opd_legal(opt_in);
        state_next.tick  = 1'b0;

        // predivider: clk_in stands for the oscillator, an enable per output period
        // illegal options stop the instruction clock rather than run out of spec
        if (state_reg.legal) begin
            if (state_reg.div_cnt >= opd_div_top(opt_in.div)) begin
                state_next.div_cnt = 2'h0;
                state_next.phase   = state_reg.phase + 2'h1;
                if (state_reg.phase == 2'(`OPD_CYCLE_PHASES - 1))
                    state_next.tick = 1'b1;
            end else begin
                state_next.div_cnt = state_reg.div_cnt + 2'h1;
            end
        end

        // the return pin toggles only while it is the oscillator's
        state_next.osc_ret = shared_is_port ? 1'b0 : ~state_reg.osc_ret;

        // port drivers: low output enable means driving low, high releases
        state_next.pins.o    = state_reg.port_data;
        state_next.pins.oe_n = state_reg.port_data;
        state_next.pins.pu   = ~opt_in.od;
        if (!shared_is_port) begin
            state_next.pins.oe_n[12] = 1'b1;
            state_next.pins.o[12]    = 1'b0;
            state_next.pins.pu[12]   = 1'b0;
        end else if (opt_in.od[12]) begin
            state_next.pins.pu[12] = 1'b0;
        end

        // port write lands at the access edge, the one where the master sees pready
        if (psel_in && penable_in && pwrite_in && state_reg.apb.pready && addr_word == `OPD_PORT_ADDR)
            state_next.port_data = pwdata_in[12:0];

        // apb slave, zero wait states
        state_next.apb.pready  = 1'b0;
        state_next.apb.pslverr = 1'b0;
        if (psel_in && !penable_in) begin
            state_next.apb.pready = 1'b1;
            state_next.apb.prdata = 32'h0000_0000;
            unique case (addr_word)
                `OPD_CFG_ADDR: begin
                    state_next.apb.prdata[`OPD_CFG_SRC_LSB +: 2]  = opt_in.src;
                    state_next.apb.prdata[`OPD_CFG_DIV_LSB +: 2]  = opt_in.div;
                    state_next.apb.prdata[`OPD_CFG_RESC_BIT]      = opt_in.resc_high;
                    state_next.apb.prdata[`OPD_CFG_RESD_BIT]      = opt_in.resd_high;
                    state_next.apb.prdata[`OPD_CFG_LOWV_BIT]      = opt_in.low_v;
                    state_next.apb.prdata[`OPD_CFG_FREQ_LSB +: 2] = opt_in.freq;
                    state_next.apb.prdata[`OPD_CFG_OD_LSB +: 13]  = opt_in.od;
                    if (pwrite_in)
                        state_next.apb.pslverr = 1'b1;
                end
                `OPD_STATUS_ADDR: begin
                    state_next.apb.prdata[`OPD_ST_LEGAL_BIT]       = state_reg.legal;
                    state_next.apb.prdata[`OPD_ST_SHARED_BIT]      = shared_is_port;
                    state_next.apb.prdata[`OPD_ST_DIVCNT_LSB +: 2] = state_reg.div_cnt;
                    state_next.apb.prdata[`OPD_ST_PHASE_LSB +: 2]  = state_reg.phase;
                    if (pwrite_in)
                        state_next.apb.pslverr = 1'b1;
                end
                `OPD_PORT_ADDR: begin
                    state_next.apb.prdata[12:0] = state_reg.port_data;
                end
                `OPD_PIN_ADDR: begin
                    state_next.apb.prdata[12:0] = state_reg.sync2;
                    if (!shared_is_port)
                        state_next.apb.prdata[12] = 1'b0;
                    if (pwrite_in)
                        state_next.apb.pslverr = 1'b1;
                end
                default: state_next.apb.pslverr = 1'b1;
            endcase
        end else if (!psel_in) begin
            state_next.apb.prdata = 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // reset leaves all port bits, C and D included, released high; the C and D option level comes only from the pin flops
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg           <= '0;
            state_reg.port_data <= {`OPD_SHARED_RESET, `OPD_PORT_RESET,
                                    `OPD_PORT_RESET, `OPD_PORT_RESET};
            state_reg.pins.o    <= 13'h1FFF;
            state_reg.pins.oe_n <= 13'h1FFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // low while reset holds and up to the first edge after release
    logic reset_seen_reg;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            reset_seen_reg <= 1'b0;
        else
            reset_seen_reg <= 1'b1;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // pin flops have no async reset so the option level reaches the pins while reset
    // still holds; a constant reset value could not follow the option inputs
    // limitation: the level appears one clock after reset is asserted
    logic [12:0] pin_o_reg;
    logic [12:0] pin_oe_n_reg;
    always_ff @(posedge clk_in) begin
        if (!reset_seen_reg) begin
            pin_o_reg    <= opd_reset_pins(opt_in);
            pin_oe_n_reg <= opd_reset_pins(opt_in);
        end else begin
            pin_o_reg    <= state_reg.pins.o;
            pin_oe_n_reg <= state_reg.pins.oe_n;
        end
    end

    assign apb_out            = state_reg.apb;
    assign pins_out.o         = pin_o_reg;
    assign pins_out.oe_n      = pin_oe_n_reg;
    assign pins_out.pu        = state_reg.pins.pu;
    assign cycle_tick_out     = state_reg.tick;
    assign osc_return_pin_out = state_reg.osc_ret;
    assign cfg_legal_out      = state_reg.legal;

endmodule : opd_core

`default_nettype wire

// ### logic/opd_defines.svh
`ifndef OPD_DEFINES_SVH
`define OPD_DEFINES_SVH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define OPD_CFG_ADDR     12'h000
`define OPD_STATUS_ADDR  12'h004
`define OPD_PORT_ADDR    12'h008
`define OPD_PIN_ADDR     12'h00C

// ---------------------------------------------------------------
// configuration word fields
// ---------------------------------------------------------------
`define OPD_CFG_SRC_LSB      0
`define OPD_CFG_DIV_LSB      2
`define OPD_CFG_RESC_BIT     4
`define OPD_CFG_RESD_BIT     5
`define OPD_CFG_LOWV_BIT     6
`define OPD_CFG_FREQ_LSB     8
`define OPD_CFG_OD_LSB       12

// ---------------------------------------------------------------
// status word fields
// ---------------------------------------------------------------
`define OPD_ST_LEGAL_BIT     0
`define OPD_ST_SHARED_BIT    1
`define OPD_ST_DIVCNT_LSB    4
`define OPD_ST_PHASE_LSB     8

// ---------------------------------------------------------------
// timing and reset values
// ---------------------------------------------------------------
`define OPD_CYCLE_PHASES     4
`define OPD_CLK_MHZ          25
`define OPD_PORT_RESET       4'hF
`define OPD_SHARED_RESET     1'b1

`endif

// ### logic/opd_pkg.sv
package opd_pkg;

    // oscillator source
    typedef enum logic [1:0] {
        OPD_SRC_EXT = 2'h0,
        OPD_SRC_RC  = 2'h1,
        OPD_SRC_CER = 2'h2
    } opd_src_t;

    // predivider ratio
    typedef enum logic [1:0] {
        OPD_DIV_1 = 2'h0,
        OPD_DIV_3 = 2'h1,
        OPD_DIV_4 = 2'h2
    } opd_div_t;

    // nominal resonator frequency
    typedef enum logic [1:0] {
        OPD_F_OTHER = 2'h0,
        OPD_F_400K  = 2'h1,
        OPD_F_1M    = 2'h2,
        OPD_F_4M    = 2'h3
    } opd_freq_t;

    // fixed option set
    typedef struct packed {
        logic [12:0] od;
        opd_freq_t   freq;
        logic        low_v;
        logic        resd_high;
        logic        resc_high;
        opd_div_t    div;
        opd_src_t    src;
    } opd_opt_t;

    // port pin group
    typedef struct packed {
        logic [12:0] o;
        logic [12:0] oe_n;
        logic [12:0] pu;
    } opd_pins_t;

    // apb slave response
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } opd_apb_rsp_t;

endpackage : opd_pkg

// ### bench/opd_core_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "opd_defines.svh"
module opd_core_properties
    import opd_pkg::*;
#(
    parameter int PORT_BITS = 13
) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire opd_opt_t     opt_in,
    input  wire logic         psel_in,
    input  wire logic         penable_in,
    input  wire logic         pwrite_in,
    input  wire logic [11:0]  paddr_in,
    input  wire opd_apb_rsp_t apb_out,
    input  wire opd_pins_t    pins_out,
    input  wire logic         cycle_tick_out,
    input  wire logic         osc_return_pin_out,
    input  wire logic         cfg_legal_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    logic       own;
    logic [4:0] period;
    logic [4:0] gap_reg;
    logic       seen_reg;
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // oscillator owns the shared pin; tick period in clocks
    assign own    = (opt_in.src == OPD_SRC_RC) || (opt_in.src == OPD_SRC_CER);
    assign period = (opt_in.div == OPD_DIV_1) ? 5'h04 : (opt_in.div == OPD_DIV_3) ? 5'h0C : 5'h10;
    // clocks since the previous tick; too long for a repetition
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gap_reg  <= 5'h00;
            seen_reg <= 1'b0;
        end else begin
            gap_reg  <= cycle_tick_out ? 5'h01 : gap_reg + 5'h01;
            seen_reg <= seen_reg | cycle_tick_out;
        end
    end
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_refused;
        s_setup ##0 (pwrite_in && (paddr_in != `OPD_PORT_ADDR));
    endsequence
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    reset_level_a: assert property (!$past(resetn_in) |=> pins_out.oe_n[11:4] == {{4{opt_in.resd_high}}, {4{opt_in.resc_high}}})
        else $error("port C or D reset level wrong");
    shared_pin_a: assert property (own |=> pins_out.oe_n[12] && !pins_out.pu[12])
        else $error("shared pin still acts as a port");
    osc_toggle_a: assert property (own |=> $changed(osc_return_pin_out))
        else $error("oscillator return pin stuck");
    osc_idle_a: assert property (opt_in.src == OPD_SRC_EXT |-> !osc_return_pin_out)
        else $error("oscillator return active on external clock");
    div1_legal_a: assert property (opt_in.div == OPD_DIV_1 && (own || opt_in.src == OPD_SRC_EXT) && !(opt_in.src == OPD_SRC_CER && opt_in.freq == OPD_F_4M) |=> cfg_legal_out)
        else $error("undivided path refused");
    rc_div_a: assert property (opt_in.src == OPD_SRC_RC && opt_in.div != OPD_DIV_1 |-> !cfg_legal_out)
        else $error("rc with predivider accepted");
    cer_slow_a: assert property (opt_in.src == OPD_SRC_CER && opt_in.freq == OPD_F_400K && opt_in.div != OPD_DIV_1 |-> !cfg_legal_out)
        else $error("slow resonator with predivider accepted");
    cer_fast_a: assert property (opt_in.src == OPD_SRC_CER && opt_in.freq == OPD_F_4M && (opt_in.div == OPD_DIV_1 || (opt_in.low_v && opt_in.div == OPD_DIV_3)) |-> !cfg_legal_out)
        else $error("fast resonator ratio accepted");
    tick_gap_a: assert property (cycle_tick_out && seen_reg |-> gap_reg == period)
        else $error("instruction cycle length wrong");
    apb_ready_a: assert property (s_setup |=> apb_out.pready)
        else $error("no ready in access cycle");
    apb_refuse_a: assert property (s_refused |=> apb_out.pslverr)
        else $error("write to read-only place accepted");
endmodule : opd_core_properties
bind opd_core opd_core_properties #(.PORT_BITS(PORT_BITS)) u_props (.clk_in, .resetn_in, .opt_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .apb_out, .pins_out, .cycle_tick_out, .osc_return_pin_out, .cfg_legal_out);
`default_nettype wire

// ### bench/opd_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module opd_pin_model
    import opd_pkg::*;
(
    input  wire logic      clk_in,
    input  wire opd_pins_t pins_in,
    output logic [12:0]    level_out
);
    // driven low wins; a released line without pull-up sinks low
    // settles on the falling edge, clear of the core's sampling edge
    always_ff @(negedge clk_in) begin
        level_out <= pins_in.oe_n & pins_in.pu;
    end
endmodule : opd_pin_model
`default_nettype wire

// ### bench/osc_predivider_option_logic_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "opd_defines.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t mismatch", $time); end end
module osc_predivider_option_logic_tb
    import opd_pkg::*;
;
    logic         clk_in;
    logic         resetn_in = 1'b0;
    opd_opt_t     opt = '0;
    logic [12:0]  lvl;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    opd_apb_rsp_t rsp;
    opd_pins_t    pins;
    logic         tick;
    logic         oscr;
    logic         legal;
    logic [31:0]  rdata;
    logic         rerr;
    logic [31:0]  d;
    logic         o1;
    logic         own_e;
    int           n_mismatch = 0;
    int           n_checks = 0;
    int           cyc = 0;
    int           n;
    opd_core dut (.clk_in(clk_in), .resetn_in(resetn_in), .opt_in(opt), .pin_level_in(lvl), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .apb_out(rsp),
        .pins_out(pins), .cycle_tick_out(tick), .osc_return_pin_out(oscr), .cfg_legal_out(legal));
    opd_pin_model u_pins (.clk_in(clk_in), .pins_in(pins), .level_out(lvl));
    // ---------------------------------------------------------------
    // clock, watchdog, helpers
    // ---------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    function automatic logic legal_f(opd_opt_t o);
        if (o.src > OPD_SRC_CER || o.div > OPD_DIV_4) return 1'b0;
        if (o.div != OPD_DIV_1 && o.src == OPD_SRC_RC) return 1'b0;
        if (o.div != OPD_DIV_1 && o.src == OPD_SRC_CER && o.freq == OPD_F_400K) return 1'b0;
        if (o.src == OPD_SRC_CER && o.freq == OPD_F_4M && (o.div == OPD_DIV_1 || (o.low_v && o.div == OPD_DIV_3)))
            return 1'b0;
        return 1'b1;
    endfunction : legal_f
    // options move only while reset holds the core
    task automatic do_reset(input int k, input int cycles);
        @(posedge clk_in);
        resetn_in <= 1'b0;
        @(posedge clk_in);
        opt <= opd_opt_t'({13'($urandom), k[5:4], k[6], 2'($urandom), k[3:2], k[1:0]});
        repeat (cycles) @(posedge clk_in);
        // levels must stand while reset is still held
        @(negedge clk_in);
        `CHK(pins.oe_n[11:4], {{4{opt.resd_high}}, {4{opt.resc_high}}})
        `CHK(pins.o[11:4], {{4{opt.resd_high}}, {4{opt.resc_high}}})
        @(posedge clk_in);
        resetn_in <= 1'b1;
    endtask : do_reset
    // one transfer; starts after its own rising edge, answer taken at the edge pready is high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (rsp.pready !== 1'b1);
        rdata = rsp.prdata;
        rerr  = rsp.pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic report_and_stop;
        if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'h5031A23A));
        for (int k = 0; k < 128; k++) begin
            do_reset(k, (k == 0) ? 16 : 4);
            @(posedge clk_in);
            @(negedge clk_in);
            `CHK(pins.oe_n[11:4], {{4{opt.resd_high}}, {4{opt.resc_high}}})
            o1 = oscr;
            own_e = (opt.src == OPD_SRC_RC) || (opt.src == OPD_SRC_CER);
            @(negedge clk_in);
            if (opt.src != 2'h3) `CHK(o1 ^ oscr, own_e)
            apb(1'b0, `OPD_CFG_ADDR, 32'h0);
            `CHK({rdata[24:12], rdata[9:8], rdata[6:0]}, opt)
            apb(1'b0, `OPD_STATUS_ADDR, 32'h0);
            `CHK(rdata[0], legal_f(opt))
            `CHK(legal, legal_f(opt))
            if (opt.src != 2'h3) begin
                `CHK(rdata[1], opt.src == OPD_SRC_EXT)
                `CHK(pins.pu, {own_e ? 1'b0 : ~opt.od[12], ~opt.od[11:0]})
            end
            if (legal_f(opt)) begin
                n = 0;
                do @(negedge clk_in); while (tick !== 1'b1);
                do begin
                    @(negedge clk_in);
                    n++;
                end while (tick !== 1'b1);
                `CHK(n, 4 * ((opt.div == OPD_DIV_1) ? 1 : (opt.div == OPD_DIV_3) ? 3 : 4))
            end
        end
        do_reset(0, 4);
        repeat (2) @(posedge clk_in);
        apb(1'b0, `OPD_PORT_ADDR, 32'h0);
        `CHK(rdata[12:0], 13'h1FFF)
        for (int j = 0; j < 3; j++) begin
            d = (j == 0) ? 32'h0 : $urandom;
            apb(1'b1, `OPD_PORT_ADDR, d);
            // write lands at the access edge, pins follow two edges later
            repeat (3) @(negedge clk_in);
            `CHK(pins.oe_n, d[12:0])
            `CHK(pins.o, d[12:0])
            apb(1'b0, `OPD_PORT_ADDR, 32'h0);
            `CHK(rdata[12:0], d[12:0])
            // released open-drain bits have no pull-up and read low
            apb(1'b0, `OPD_PIN_ADDR, 32'h0);
            `CHK(rdata[12:0], d[12:0] & ~opt.od)
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'((i < 2) ? i * 4 : i * 4 + 4), ~d);
            `CHK(rerr, 1'b1)
        end
        apb(1'b0, `OPD_CFG_ADDR, 32'h0);
        `CHK({rdata[24:12], rdata[9:8], rdata[6:0]}, opt)
        report_and_stop();
    end
endmodule : osc_predivider_option_logic_tb
`default_nettype wire
